// *** inc/pci_xlat_pkg.sv ***
// Constants and types shared by both ends of the window address translator
package pci_xlat_pkg;

  // ==========================================================================
  // Register map
  localparam int REG_AW = 6;
  localparam logic [REG_AW-1:0] OFF_WIN_SPAN = 6'h10;
  localparam logic [3:0] OFF_BASE = 4'h0;
  localparam logic [3:0] OFF_MASK = 4'h4;
  localparam logic [3:0] OFF_TBASE = 4'h8;
  localparam logic [REG_AW-1:0] OFF_STATUS = 6'h20;

  // ==========================================================================
  // Field layouts
  localparam int BASE_EN_BIT = 0;
  localparam int BASE_SG_BIT = 1;
  localparam int BASE_LSB = 20;
  localparam int MASK_LSB = 20;
  localparam int MASK_W = 12;
  localparam int TBASE_W = 23;
  localparam int STAT_ERR_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int ENTRY_VALID_BIT = 0;
  localparam int ENTRY_PAGE_LSB = 1;
  localparam int ENTRY_PAGE_W = 20;

  // ==========================================================================
  // Reset values
  localparam logic [31:0] RST_BASE = 32'h0000_0000;
  localparam logic [MASK_W-1:0] RST_MASK = 12'h000;
  localparam logic [TBASE_W-1:0] RST_TBASE = 23'h00_0000;

  // ==========================================================================
  // Transfer shapes
  localparam int LW_PER_LINE = 8;
  localparam logic [3:0] RD_PHASES = 4'h2;
  localparam logic [7:0] RD_BE_MASK = 8'h03;

  // ==========================================================================
  // Inbound sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH} xlState_t;

endpackage : pci_xlat_pkg

// *** inc/link_if.sv ***
// Interface joining the host end and the translator
`timescale 1ns/1ps
interface link_if;
  import pci_xlat_pkg::*;

  logic [REG_AW-1:0] regAddr;
  logic [31:0] regWdata;
  logic regWr;
  logic regRd;
  logic [31:0] regRdata;
  logic obValid;
  logic obWrite;
  logic [31:0] obAddr;
  logic [7:0] obMask;
  logic pciValid;
  logic [31:0] pciAddr;
  logic [3:0] pciPhases;
  logic [7:0] pciBeMask;
  logic ibValid;
  logic [31:0] ibAddr;
  logic ibReady;
  logic ibMiss;
  logic sysValid;
  logic [28:0] sysAddr;
  logic sgError;
  logic memRdValid;
  logic [30:0] memRdAddr;
  logic memDataValid;
  logic [63:0] memData;

  modport dev (
    input regAddr, regWdata, regWr, regRd,
    output regRdata,
    input obValid, obWrite, obAddr, obMask,
    output pciValid, pciAddr, pciPhases, pciBeMask,
    input ibValid, ibAddr,
    output ibReady, ibMiss, sysValid, sysAddr, sgError,
    output memRdValid, memRdAddr,
    input memDataValid, memData
  );

  modport host (
    output regAddr, regWdata, regWr, regRd,
    input regRdata,
    output obValid, obWrite, obAddr, obMask,
    input pciValid, pciAddr, pciPhases, pciBeMask,
    output ibValid, ibAddr,
    input ibReady, ibMiss, sysValid, sysAddr, sgError,
    input memRdValid, memRdAddr,
    output memDataValid, memData
  );

endinterface : link_if

// *** hw/pci_window_address_translator.sv ***
// Dense space outbound mapping and inbound window translation
`timescale 1ns/1ps

// Operation
// - Dense space maps processor longwords one-to-one
// - Longword minimum; line writes, quadword reads
// - Reads become two-phase quadword bursts
// - Writes become bursts of up to eight
// - Address bits 31:5 copied from host
// - Read bits 4:3 from mask, bit2 zero
// - Write bits 4:2 from first written longword
// - Write length from mask; any nonzero pattern accepted
// - Masked longwords sent with byte enables off
// - Targets tolerate phases with no byte enables
// - Two windows: base, size mask, translated base
// - Size mask contiguous over bits 31:20
// - Hit when enabled and unmasked bits match
// - Each window has own enable bit
// - Software keeps windows disjoint and aligned
// - Direct map: translated base over PCI bits
// - Software clears translated base below size
// - Scatter-gather fetches entry at base plus offset
// - Map size follows window; quadword aligned entries
// - Entry: valid bit0, page bits 20:1
// - Final address is page plus bits 12:5
module pci_window_address_translator
  import pci_xlat_pkg::*;
#(
  parameter int NUM_WIN = 2
) (
  input wire logic clk,
  input wire logic srst,
  link_if.dev link
);

  // ==========================================================================
  // Configuration check
  generate
    if (NUM_WIN != 2) begin : badWinCount
      $error("Address decode serves exactly two windows");
    end
  endgenerate

  // ==========================================================================
  // State
  typedef struct packed {
    xlState_t st;
    logic [NUM_WIN-1:0][31:0] base;
    logic [NUM_WIN-1:0][MASK_W-1:0] mask;
    logic [NUM_WIN-1:0][TBASE_W-1:0] tbase;
    logic errSticky;
    logic [31:0] regRdata;
    logic pciValid;
    logic [31:0] pciAddr;
    logic [3:0] pciPhases;
    logic [7:0] pciBeMask;
    logic ibReady;
    logic ibMiss;
    logic sysValid;
    logic [28:0] sysAddr;
    logic sgError;
    logic memRdValid;
    logic [30:0] memRdAddr;
    logic [7:0] pageOff;
  } devState_t;

  devState_t q;
  devState_t d;

  // ==========================================================================
  // Helpers
  function automatic logic [2:0] lowIdx(input logic [7:0] m);
    lowIdx = 3'h0;
    for (int i = LW_PER_LINE - 1; i >= 0; i--) begin
      if (m[i]) begin
        lowIdx = 3'(i);
      end
    end
  endfunction : lowIdx

  function automatic logic [2:0] highIdx(input logic [7:0] m);
    highIdx = 3'h0;
    for (int i = 0; i < LW_PER_LINE; i++) begin
      if (m[i]) begin
        highIdx = 3'(i);
      end
    end
  endfunction : highIdx

  // ==========================================================================
  // Next state
  always_comb begin : nextState
    logic found;
    logic useSg;
    logic [MASK_W-1:0] m;
    logic [TBASE_W-1:0] tb;
    logic [27:0] dirMask;
    logic [27:0] dirAddr;
    logic [29:0] sgMask;
    logic [29:0] mapAddr;
    logic [2:0] lo;
    logic [2:0] hi;
    logic [3:0] span;
    logic [REG_AW-1:0] ra;
    int selWin;
    found = 1'b0;
    useSg = 1'b0;
    m = RST_MASK;
    tb = RST_TBASE;
    dirMask = 28'h000_0000;
    dirAddr = 28'h000_0000;
    sgMask = 30'h0000_0000;
    mapAddr = 30'h0000_0000;
    lo = 3'h0;
    hi = 3'h0;
    span = 4'h0;
    ra = link.regAddr;
    selWin = 0;
    d = q;
    d.regRdata = 32'h0000_0000;
    d.pciValid = 1'b0;
    d.sysValid = 1'b0;
    d.ibMiss = 1'b0;
    d.sgError = 1'b0;
    d.memRdValid = 1'b0;

    // Register writes; status error bit is write-one-to-clear
    if (link.regWr) begin
      if (ra < OFF_STATUS) begin
        case (ra[3:0])
          OFF_BASE: begin
            d.base[ra[4]] = link.regWdata;
          end
          OFF_MASK: begin
            d.mask[ra[4]] = link.regWdata[MASK_LSB +: MASK_W];
          end
          OFF_TBASE: begin
            d.tbase[ra[4]] = link.regWdata[TBASE_W-1:0];
          end
          default: begin
          end
        endcase
      end else if (ra == OFF_STATUS) begin
        if (link.regWdata[STAT_ERR_BIT]) begin
          d.errSticky = 1'b0;
        end
      end
    end

    // Register reads, data valid in the following cycle only
    if (link.regRd) begin
      if (ra < OFF_STATUS) begin
        case (ra[3:0])
          OFF_BASE: begin
            d.regRdata = q.base[ra[4]];
          end
          OFF_MASK: begin
            d.regRdata[MASK_LSB +: MASK_W] = q.mask[ra[4]];
          end
          OFF_TBASE: begin
            d.regRdata[TBASE_W-1:0] = q.tbase[ra[4]];
          end
          default: begin
          end
        endcase
      end else if (ra == OFF_STATUS) begin
        d.regRdata[STAT_ERR_BIT] = q.errSticky;
        d.regRdata[STAT_BUSY_BIT] = (q.st == ST_FETCH);
      end
    end

    // Outbound dense space mapping
    if (link.obValid) begin
      if (link.obWrite) begin
        if (link.obMask != 8'h00) begin
          lo = lowIdx(link.obMask);
          hi = highIdx(link.obMask);
          span = {1'b0, hi} - {1'b0, lo} + 4'h1;
          d.pciValid = 1'b1;
          d.pciAddr = {link.obAddr[31:5], lo, 2'b00};
          d.pciPhases = span;
          d.pciBeMask = link.obMask >> lo;
        end
      end else begin
        d.pciValid = 1'b1;
        d.pciAddr = {link.obAddr[31:5], link.obMask[1:0], 3'b000};
        d.pciPhases = RD_PHASES;
        d.pciBeMask = RD_BE_MASK;
      end
    end

    // Inbound window decode; lower window wins on overlap
    for (int w = NUM_WIN - 1; w >= 0; w--) begin
      if (q.base[w][BASE_EN_BIT] &&
          ((link.ibAddr[31:BASE_LSB] & ~q.mask[w]) ==
           (q.base[w][31:BASE_LSB] & ~q.mask[w]))) begin
        found = 1'b1;
        selWin = w;
      end
    end
    m = q.mask[selWin];
    tb = q.tbase[selWin];
    useSg = q.base[selWin][BASE_SG_BIT];
    dirMask = {1'b0, m, 15'h7FFF};
    dirAddr = ({tb, 5'h00} & ~dirMask) |
              ({1'b0, link.ibAddr[31:5]} & dirMask);
    sgMask = {11'h000, m, 7'h7F};
    mapAddr = ({tb, 7'h00} & ~sgMask) |
              ({11'h000, link.ibAddr[31:13]} & sgMask);

    case (q.st)
      ST_IDLE: begin
        if (link.ibValid && q.ibReady) begin
          if (!found) begin
            d.ibMiss = 1'b1;
          end else if (useSg) begin
            d.memRdValid = 1'b1;
            d.memRdAddr = {1'b0, mapAddr};
            d.pageOff = link.ibAddr[12:5];
            d.ibReady = 1'b0;
            d.st = ST_FETCH;
          end else begin
            d.sysValid = 1'b1;
            d.sysAddr = {1'b0, dirAddr};
          end
        end
      end
      ST_FETCH: begin
        if (link.memDataValid) begin
          if (link.memData[ENTRY_VALID_BIT]) begin
            d.sysValid = 1'b1;
            d.sysAddr = {1'b0,
              link.memData[ENTRY_PAGE_LSB +: ENTRY_PAGE_W],
              q.pageOff};
          end else begin
            d.sgError = 1'b1;
            d.errSticky = 1'b1;
          end
          d.ibReady = 1'b1;
          d.st = ST_IDLE;
        end
      end
      default: begin
        d.st = ST_IDLE;
        d.ibReady = 1'b1;
      end
    endcase

    if (srst) begin
      d = '0;
      d.st = ST_IDLE;
      for (int w = 0; w < NUM_WIN; w++) begin
        d.base[w] = RST_BASE;
        d.mask[w] = RST_MASK;
        d.tbase[w] = RST_TBASE;
      end
      d.ibReady = 1'b1;
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk) begin
    q <= d;
  end

  // ==========================================================================
  // Outputs
  assign link.regRdata = q.regRdata;
  assign link.pciValid = q.pciValid;
  assign link.pciAddr = q.pciAddr;
  assign link.pciPhases = q.pciPhases;
  assign link.pciBeMask = q.pciBeMask;
  assign link.ibReady = q.ibReady;
  assign link.ibMiss = q.ibMiss;
  assign link.sysValid = q.sysValid;
  assign link.sysAddr = q.sysAddr;
  assign link.sgError = q.sgError;
  assign link.memRdValid = q.memRdValid;
  assign link.memRdAddr = q.memRdAddr;

endmodule : pci_window_address_translator

// *** hw/pci_bridge_host_end.sv ***
// Host and PCI master end that feeds the translator
`timescale 1ns/1ps
module pci_bridge_host_end
  import pci_xlat_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  link_if.host link,
  input wire logic [REG_AW-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [31:0] reqAddr,
  input wire logic [7:0] reqMask,
  output logic pciOutValid,
  output logic [31:0] pciOutAddr,
  output logic [3:0] pciOutPhases,
  output logic [7:0] pciOutBeMask,
  input wire logic inValid,
  input wire logic [31:0] inAddr,
  output logic inReady,
  output logic inMiss,
  output logic sysOutValid,
  output logic [28:0] sysOutAddr,
  output logic mapError,
  output logic memReqValid,
  output logic [30:0] memReqAddr,
  input wire logic memRespValid,
  input wire logic [63:0] memResp
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic obValid;
    logic obWrite;
    logic [31:0] obAddr;
    logic [7:0] obMask;
    logic ibValid;
    logic [31:0] ibAddr;
    logic inReady;
    logic memDataValid;
    logic [63:0] memData;
    logic pciValid;
    logic [31:0] pciAddr;
    logic [3:0] pciPhases;
    logic [7:0] pciBeMask;
    logic miss;
    logic sysValid;
    logic [28:0] sysAddr;
    logic err;
    logic memReqValid;
    logic [30:0] memReqAddr;
  } hostState_t;

  hostState_t q;
  hostState_t d;

  // ==========================================================================
  // Next state
  always_comb begin
    d = q;
    // Longword masks only; byte and word granularity cannot be expressed
    d.obValid = reqValid;
    d.obWrite = reqWrite;
    d.obAddr = reqAddr;
    d.obMask = reqMask;
    // One request held until the translator takes it
    if (q.ibValid && link.ibReady) begin
      d.ibValid = 1'b0;
    end
    if (inValid && q.inReady) begin
      d.ibValid = 1'b1;
      d.ibAddr = inAddr;
    end
    d.inReady = !d.ibValid;
    d.memDataValid = memRespValid;
    d.memData = memResp;
    // Phases with byte enables off are passed on untouched
    d.pciValid = link.pciValid;
    d.pciAddr = link.pciAddr;
    d.pciPhases = link.pciPhases;
    d.pciBeMask = link.pciBeMask;
    d.miss = link.ibMiss;
    d.sysValid = link.sysValid;
    d.sysAddr = link.sysAddr;
    d.err = link.sgError;
    d.memReqValid = link.memRdValid;
    d.memReqAddr = link.memRdAddr;
    if (srst) begin
      d = '0;
      d.inReady = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  // ==========================================================================
  // Register path goes straight through so read data keep one-cycle latency
  assign link.regAddr = regAddr;
  assign link.regWdata = regWdata;
  assign link.regWr = regWr;
  assign link.regRd = regRd;
  assign regRdata = link.regRdata;

  assign link.obValid = q.obValid;
  assign link.obWrite = q.obWrite;
  assign link.obAddr = q.obAddr;
  assign link.obMask = q.obMask;
  assign link.ibValid = q.ibValid;
  assign link.ibAddr = q.ibAddr;
  assign link.memDataValid = q.memDataValid;
  assign link.memData = q.memData;

  assign pciOutValid = q.pciValid;
  assign pciOutAddr = q.pciAddr;
  assign pciOutPhases = q.pciPhases;
  assign pciOutBeMask = q.pciBeMask;
  assign inReady = q.inReady;
  assign inMiss = q.miss;
  assign sysOutValid = q.sysValid;
  assign sysOutAddr = q.sysAddr;
  assign mapError = q.err;
  assign memReqValid = q.memReqValid;
  assign memReqAddr = q.memReqAddr;

endmodule : pci_bridge_host_end

// *** testbench/pci_xlat_sva.sv ***
// Assertions on the link between host end and translator
`timescale 1ns/1ps
module pci_xlat_sva (
  input wire logic clk,
  input wire logic srst,
  input wire logic obValid,
  input wire logic obWrite,
  input wire logic [31:0] obAddr,
  input wire logic [7:0] obMask,
  input wire logic pciValid,
  input wire logic [31:0] pciAddr,
  input wire logic [3:0] pciPhases,
  input wire logic [7:0] pciBeMask,
  input wire logic ibValid,
  input wire logic ibReady,
  input wire logic ibMiss,
  input wire logic sysValid,
  input wire logic [28:0] sysAddr,
  input wire logic sgError,
  input wire logic memRdValid,
  input wire logic [30:0] memRdAddr,
  input wire logic memDataValid,
  input wire logic [63:0] memData
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // ==========
  // Outbound
  a_read_shape: assert property (obValid && !obWrite |=> pciValid &&
    pciPhases == 4'h2 && pciBeMask == 8'h03 &&
    pciAddr == {$past(obAddr[31:5]), $past(obMask[1:0]), 3'h0})
    else $error("read burst shape wrong");
  a_write_start: assert property (obValid && obWrite && obMask[0] |=>
    pciValid && pciAddr == {$past(obAddr[31:5]), 5'h00})
    else $error("write address wrong");
  a_full_line: assert property (obValid && obWrite && obMask == 8'hFF |=>
    pciPhases == 4'h8 && pciBeMask == 8'hFF)
    else $error("full line burst wrong");
  a_write_span: assert property (obValid && obWrite && obMask != 8'h00 |=>
    pciValid && pciBeMask == ($past(obMask) >> pciAddr[4:2]) &&
    pciBeMask[0] && pciBeMask[pciPhases - 4'h1])
    else $error("write span or byte enables wrong");
  a_empty_write: assert property (obValid && obWrite && obMask == 8'h00 |=>
    !pciValid)
    else $error("empty write issued");
  a_pci_cause: assert property (pciValid |-> $past(obValid))
    else $error("unrequested cycle");

  // ==========
  // Inbound
  a_ib_answer: assert property (ibValid && ibReady |=>
    $onehot({ibMiss, sysValid, memRdValid}))
    else $error("inbound answer missing");
  a_fetch_busy: assert property (memRdValid |-> !ibReady &&
    !memRdAddr[30])
    else $error("fetch not busy or bad address");
  a_entry_use: assert property (memDataValid && !ibReady && memData[0] |=>
    sysValid && !sgError && sysAddr[28:8] == {1'b0, $past(memData[20:1])})
    else $error("page address wrong");
  a_entry_bad: assert property (memDataValid && !ibReady && !memData[0] |=>
    sgError && !sysValid)
    else $error("invalid entry not refused");
  a_sys_low: assert property (sysValid |-> !sysAddr[28])
    else $error("system bit 33 set");

  c_full_line: cover property (obValid && obWrite && obMask == 8'hFF);
  c_sg_fetch: cover property (memDataValid && !ibReady);
  c_miss: cover property (ibMiss);
endmodule : pci_xlat_sva

// *** testbench/test_pci_window_address_translator.sv ***
// Self-checking bench for the host end and translator pair
`timescale 1ns/1ps
module test_pci_window_address_translator;
  import pci_xlat_pkg::*;
  localparam logic [31:0] SG_ADDR = 32'h2005_6780;
  logic clk, srst, regWr, regRd, reqValid, reqWrite, pciOutValid;
  logic inValid, inReady, inMiss, sysOutValid, mapError;
  logic memReqValid, memRespValid;
  logic [REG_AW-1:0] regAddr;
  logic [31:0] regWdata, regRdata, reqAddr, pciOutAddr, inAddr;
  logic [7:0] reqMask, pciOutBeMask;
  logic [3:0] pciOutPhases;
  logic [28:0] sysOutAddr;
  logic [30:0] memReqAddr;
  logic [63:0] memResp;
  logic [7:0] wm [7] = '{8'hFF, 8'h01, 8'h80, 8'h02, 8'h0C, 8'h5A, 8'h00};
  int bad_count, samples_checked;

  link_if link ();
  pci_window_address_translator #(.NUM_WIN(2))
    pci_window_address_translator_inst (.clk, .srst, .link);
  pci_bridge_host_end pci_bridge_host_end_inst (.clk, .srst, .link,
    .regAddr, .regWdata, .regWr, .regRd, .regRdata, .reqValid, .reqWrite,
    .reqAddr, .reqMask, .pciOutValid, .pciOutAddr, .pciOutPhases,
    .pciOutBeMask, .inValid, .inAddr, .inReady, .inMiss, .sysOutValid,
    .sysOutAddr, .mapError, .memReqValid, .memReqAddr, .memRespValid,
    .memResp);
  pci_xlat_sva pci_xlat_sva_inst (.clk, .srst, .obValid(link.obValid),
    .obWrite(link.obWrite), .obAddr(link.obAddr), .obMask(link.obMask),
    .pciValid(link.pciValid), .pciAddr(link.pciAddr),
    .pciPhases(link.pciPhases), .pciBeMask(link.pciBeMask),
    .ibValid(link.ibValid), .ibReady(link.ibReady), .ibMiss(link.ibMiss),
    .sysValid(link.sysValid), .sysAddr(link.sysAddr),
    .sgError(link.sgError), .memRdValid(link.memRdValid),
    .memRdAddr(link.memRdAddr), .memDataValid(link.memDataValid),
    .memData(link.memData));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ==========
  // Tasks
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  task automatic wr(input logic [REG_AW-1:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [REG_AW-1:0] a, input logic [31:0] e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(posedge clk);
    check(regRdata, e);
  endtask : rd

  task automatic ob(input logic w, input logic [31:0] a, input logic [7:0] m);
    logic [2:0] lo, hi;
    logic seen;
    lo = 3'h0;
    hi = 3'h0;
    seen = 1'b0;
    for (int i = 7; i >= 0; i--) if (m[i]) lo = 3'(i);
    for (int i = 0; i < 8; i++) if (m[i]) hi = 3'(i);
    reqValid <= 1'b1;
    reqWrite <= w;
    reqAddr <= a;
    reqMask <= m;
    @(posedge clk);
    reqValid <= 1'b0;
    repeat (6) begin
      @(posedge clk);
      if (pciOutValid === 1'b1) begin
        seen = 1'b1;
        check(pciOutAddr, w ? {a[31:5], lo, 2'h0} : {a[31:5], m[1:0], 3'h0});
        check(pciOutPhases, w ? 4'(hi - lo) + 4'h1 : 4'h2);
        check(pciOutBeMask, w ? m >> lo : 8'h03);
      end
    end
    check(seen, !w || m != 8'h00);
  endtask : ob

  task automatic ib(input logic [31:0] a, input logic [63:0] ent,
      input int k, input logic [28:0] es, input logic [30:0] em);
    int kind;
    kind = 3;
    check(inReady, 1'b1);
    inValid <= 1'b1;
    inAddr <= a;
    @(posedge clk);
    inValid <= 1'b0;
    for (int i = 0; i < 12 && kind == 3; i++) begin
      @(posedge clk);
      if (i == 0) check(inReady, 1'b0);
      if (memReqValid === 1'b1) begin
        check(memReqAddr, em);
        memRespValid <= 1'b1;
        memResp <= ent;
        @(posedge clk);
        memRespValid <= 1'b0;
        memResp <= ~ent;
      end
      if (inMiss === 1'b1) kind = 0;
      if (sysOutValid === 1'b1) kind = 1;
      if (mapError === 1'b1) kind = 2;
      if (kind == 1) check(sysOutAddr, es);
    end
    if (kind == 3) begin
      bad_count++;
      stop_test();
    end
    check(kind, k);
  endtask : ib

  function automatic logic [28:0] dmap(input logic [31:0] a);
    return 29'((33'h0_8000_0000 | 33'(a & 32'h003F_FFFF)) >> 5);
  endfunction : dmap

  // ==========
  // Sequence
  initial begin
    srst = 1'b1;
    {regWr, regRd, reqValid, reqWrite, inValid, memRespValid} = 6'h00;
    {regAddr, regWdata, reqAddr, reqMask, inAddr} = '0;
    memResp = 64'h0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 11; i++) rd(6'(i * 4), 32'h0);
    wr(6'h04, 32'hFFFF_FFFF);
    rd(6'h04, 32'hFFF0_0000);
    wr(6'h08, 32'hFFFF_FFFF);
    rd(6'h08, 32'h007F_FFFF);
    wr(6'h3C, 32'h1234_5678);
    rd(6'h3C, 32'h0);
    wr(6'h00, 32'h1000_0001);
    wr(6'h04, 32'h0030_0000);
    wr(6'h08, 32'h0020_0000);
    wr(6'h10, 32'h2000_0003);
    wr(6'h14, 32'h0);
    wr(6'h18, 32'h0001_0000);
    rd(6'h10, 32'h2000_0003);
    for (int i = 0; i < 4; i++) ob(1'b0, 32'hA000_1FFF, 8'(i));
    foreach (wm[i]) ob(1'b1, 32'hB765_43FF, wm[i]);
    ib(32'h1012_3460, 64'h0, 1, dmap(32'h1012_3460), 31'h0);
    ib(32'h103F_FFE0, 64'h0, 1, dmap(32'h103F_FFE0), 31'h0);
    ib(32'h1040_0000, 64'h0, 0, 29'h0, 31'h0);
    ib(32'h0FFF_FFE0, 64'h0, 0, 29'h0, 31'h0);
    ib(SG_ADDR, {43'h0, 20'h54321, 1'b1}, 1, {1'b0, 20'h54321,
      SG_ADDR[12:5]}, 31'h0080_002B);
    ib(SG_ADDR, {43'h0, 20'h54321, 1'b0}, 2, 29'h0, 31'h0080_002B);
    rd(6'h20, 32'h1);
    wr(6'h20, 32'h1);
    rd(6'h20, 32'h0);
    wr(6'h00, 32'h1000_0000);
    ib(32'h1012_3460, 64'h0, 0, 29'h0, 31'h0);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(6'h10, 32'h0);
    ib(SG_ADDR, 64'h0, 0, 29'h0, 31'h0);
    stop_test();
  end
endmodule : test_pci_window_address_translator
